// [rtl/dic_cfg.svh]
// Register map, field positions, reset values and scaling constants
// for the interpolation chain. Definitions only.
`ifndef DIC_CFG_SVH
`define DIC_CFG_SVH
// Word offsets inside the control page (address bits 7:0)
`define DIC_OFS_CTRL 8'h00
`define DIC_OFS_CIC 8'h04
`define DIC_OFS_FLUSH 8'h08
`define DIC_OFS_STAT 8'h0C
// Pages selected by address bits 11:8
`define DIC_PG_REGS 4'h0
`define DIC_PG_PCOEF 4'h1
`define DIC_PG_CCOEF 4'h2
// Control word fields
`define DIC_F_DUAL 0
`define DIC_F_SYMP 1
`define DIC_F_SYMC 2
`define DIC_F_PGAIN 3
`define DIC_F_PTAP 8:4
`define DIC_F_CTAP 13:9
`define DIC_F_RATIO 18:14
`define DIC_F_CGAIN 21:19
// CIC word fields
`define DIC_F_SCA 4:0
`define DIC_F_MSKA 10:5
`define DIC_F_SCB 20:16
`define DIC_F_MSKB 26:21
// Flush word fields
`define DIC_F_DIS 3:0
`define DIC_F_TEST 7:4
`define DIC_F_CLR 11:8
`define DIC_F_IMSK 15:12
// Status word fields
`define DIC_F_ERR 3:0
`define DIC_F_IRQ 4
// Writable masks and reset values
`define DIC_CTRL_MSK 32'h003FFFFF
`define DIC_CIC_MSK 32'h07FF07FF
`define DIC_FLUSH_MSK 32'h0000FFFF
`define DIC_CTRL_RST 32'h0001DFF0
`define DIC_CIC_RST 32'h00000000
`define DIC_FLUSH_RST 32'h00000000
// Scaling: unity FIR gain points and CIC shift origin; FIR coefficient counts
`define DIC_PFIR_BASE 6'h11
`define DIC_CFIR_BASE 6'h13
`define DIC_CIC_TOP 5'h1F
`define DIC_PFIR_NCOEF 63
`define DIC_CFIR_NCOEF 47
`endif

// [rtl/dic_chain.sv]
// Transmit interpolation chain: shaping FIR x2, compensating FIR x2,
// six-stage CIC x1..x32 with error flush, Wishbone register slave.
// Assumes one clock, synchronous inputs, classic Wishbone master.
`timescale 1ns/10ps
`include "dic_cfg.svh"

// Time-shared polyphase FIR interpolating by two over two lanes, four in dual
module dic_fir #(
  parameter int NCOEF = 63,
  parameter int GW = 1,
  parameter logic [5:0] BASE = 6'h11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cwe_i,
  input wire logic [5:0] caddr_i,
  input wire logic [17:0] cdata_i,
  input wire logic [4:0] taps_i,
  input wire logic sym_i,
  input wire logic dual_i,
  input wire logic [GW-1:0] gain_i,
  input wire logic in_valid_i,
  input wire dic_pkg::quad_s in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output dic_pkg::quad_s out_data_o,
  input wire logic out_ready_i
);
  logic signed [17:0] coef_q [NCOEF];
  logic [35:0] hist_q [2][32];
  dic_pkg::fir_state_e st_q;
  logic ph_q;
  logic [1:0] ch_q;
  logic [5:0] k_q;
  logic signed [42:0] acc_q;
  logic [71:0] res_q;
  logic [5:0] kk;
  logic signed [17:0] cf;
  logic [35:0] hv;
  logic signed [18:0] xv;
  logic signed [42:0] acc_d;
  logic signed [50:0] sc;
  logic last_tap;
  logic last_ch;

  // Saturate a scaled sum to 18 bits instead of wrapping
  function automatic dic_pkg::samp_t sat18(logic signed [50:0] v);
    if (v[50:17] == {34{v[17]}}) begin
      sat18 = v[17:0];
    end else if (v[50]) begin
      sat18 = 18'h20000;
    end else begin
      sat18 = 18'h1FFFF;
    end
  endfunction

  // Tap fetch; symmetric mode reads only the lower coefficient half
  always_comb begin
    kk = (sym_i && k_q > {1'b0, taps_i}) ? 6'({taps_i, 1'b0} - k_q) : k_q;
    cf = (int'(kk) < NCOEF) ? coef_q[kk] : 18'h00000;
    hv = hist_q[ch_q[1]][k_q[5:1]];
    xv = ch_q[0] ? 19'(signed'(hv[17:0])) : 19'(signed'(hv[35:18]));
    acc_d = acc_q + 43'(xv * cf); // 19x18 multiply, full precision
    sc = (51'(acc_d) <<< gain_i) >>> BASE; // Gain shift
    last_tap = (7'(k_q) + 7'h02) > {1'b0, taps_i, 1'b0}; // 2f+1 taps
    last_ch = ch_q == (dual_i ? 2'h3 : 2'h1); // A/B lanes in dual
  end

  // Coefficient store, one set shared by both signals
  always_ff @(posedge clk_i) begin
    if (ce_i && cwe_i && int'(caddr_i) < NCOEF) begin
      coef_q[caddr_i] <= cdata_i;
    end
  end

  // Sample history: 32 cells of 36 bits per signal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < 32; j++) begin
        hist_q[0][j] <= 36'h000000000;
        hist_q[1][j] <= 36'h000000000;
      end
    end else if (ce_i && st_q == dic_pkg::FIR_IDLE && in_valid_i) begin
      for (int j = 31; j > 0; j--) begin
        hist_q[0][j] <= hist_q[0][j-1];
        hist_q[1][j] <= hist_q[1][j-1];
      end
      hist_q[0][0] <= {in_data_i.ai, in_data_i.aq};
      hist_q[1][0] <= {in_data_i.bi, in_data_i.bq};
    end
  end

  // Sequencer: two output phases per input sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= dic_pkg::FIR_IDLE;
      ph_q <= 1'b0;
      ch_q <= 2'h0;
      k_q <= 6'h00;
      acc_q <= '0;
      res_q <= '0;
    end else if (ce_i) begin
      case (st_q)
        dic_pkg::FIR_IDLE: begin
          if (in_valid_i) begin
            st_q <= dic_pkg::FIR_MAC;
            ph_q <= 1'b0;
            ch_q <= 2'h0;
            k_q <= 6'h00;
            acc_q <= '0;
            res_q <= '0;
          end
        end
        dic_pkg::FIR_MAC: begin
          if (last_tap) begin
            res_q[(3 - int'(ch_q)) * 18 +: 18] <= sat18(sc);
            acc_q <= '0;
            k_q <= {5'h00, ph_q};
            ch_q <= ch_q + 2'h1;
            if (last_ch) begin
              st_q <= dic_pkg::FIR_OUT;
            end
          end else begin
            acc_q <= acc_d;
            k_q <= k_q + 6'h02;
          end
        end
        dic_pkg::FIR_OUT: begin
          if (out_ready_i) begin
            ch_q <= 2'h0;
            if (!ph_q) begin
              ph_q <= 1'b1; // Odd phase uses odd coefficients
              k_q <= 6'h01;
              st_q <= dic_pkg::FIR_MAC;
            end else begin
              st_q <= dic_pkg::FIR_IDLE;
            end
          end
        end
        default: st_q <= dic_pkg::FIR_IDLE;
      endcase
    end
  end

  assign in_ready_o = st_q == dic_pkg::FIR_IDLE;
  assign out_valid_o = st_q == dic_pkg::FIR_OUT;
  assign out_data_o = dic_pkg::quad_s'(res_q);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_tap_bound: assert property (
    st_q == dic_pkg::FIR_MAC |-> k_q <= {taps_i, 1'b0})
    else $error("FIR tap index beyond programmed length");
  a_first_out: assert property (
    (st_q == dic_pkg::FIR_IDLE && in_valid_i) |-> ##[1:300] out_valid_o)
    else $error("FIR gave no output after taking a sample");
  a_second_phase: assert property (
    (out_valid_o && out_ready_i && !ph_q) |=>
      (st_q == dic_pkg::FIR_MAC && k_q == 6'h01))
    else $error("FIR skipped the odd output phase");
  c_sym_mac: cover property (sym_i && st_q == dic_pkg::FIR_MAC && k_q > 6'h20);
endmodule

// One CIC lane: six combs, zero stuffing, six integrators, scaler
module dic_cic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic take_i,
  input wire dic_pkg::samp_t x_i,
  input wire logic [5:0] mask_i,
  input wire logic [4:0] scale_i,
  input wire logic flush_i,
  output dic_pkg::samp_t y_o,
  output logic ovf_o
);
  logic signed [23:0] d1_q [6];
  logic signed [23:0] d2_q [6];
  logic signed [23:0] cv [7];
  logic signed [49:0] ig_q [6];
  logic signed [49:0] sh;
  logic clr;

  // Comb chain, 24-bit, delay 2 where mask bit set
  always_comb begin
    cv[0] = 24'(x_i);
    for (int j = 0; j < 6; j++) begin
      cv[j+1] = cv[j] - (mask_i[j] ? d2_q[j] : d1_q[j]);
    end
    sh = ig_q[5] >>> (`DIC_CIC_TOP - scale_i); // 50 to 18 bits
    clr = flush_i || !en_i;
  end

  // Runaway bias: scaled sum no longer fits the output
  assign ovf_o = en_i && (sh[49:17] != {33{sh[17]}});

  // Comb delays advance at the low rate; flush clears them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < 6; j++) begin
        d1_q[j] <= '0;
        d2_q[j] <= '0;
      end
    end else if (ce_i && (clr || take_i)) begin
      for (int j = 0; j < 6; j++) begin
        d1_q[j] <= clr ? 24'h000000 : cv[j];
        d2_q[j] <= clr ? 24'h000000 : d1_q[j];
      end
    end
  end

  // Integrators run every cycle on the zero-stuffed comb output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int j = 0; j < 6; j++) begin
        ig_q[j] <= '0;
      end
      y_o <= '0;
    end else if (ce_i) begin
      if (clr) begin
        for (int j = 0; j < 6; j++) begin
          ig_q[j] <= '0;
        end
        y_o <= '0;
      end else begin
        ig_q[0] <= ig_q[0] + (take_i ? 50'(cv[6]) : 50'h0);
        for (int j = 1; j < 6; j++) begin
          ig_q[j] <= ig_q[j] + ig_q[j-1];
        end
        y_o <= sh[17:0];
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_flush_clears: assert property (
    flush_i |=> (ig_q[5] == 50'h0 && y_o == 18'h00000))
    else $error("CIC state survived a flush");
  a_lane_off: assert property (
    !en_i [*2] |-> y_o == 18'h00000)
    else $error("Disabled CIC lane drives data");
endmodule

module dic_chain (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid_i,
  input wire dic_pkg::quad_s in_data_i,
  output logic in_ready_o,
  output dic_pkg::quad_s out_data_o,
  output logic irq_o
);
  logic [31:0] ctrl_q;
  logic [31:0] cicr_q;
  logic [31:0] flr_q;
  logic [3:0] test_p_q;
  logic [3:0] clr_p_q;
  logic [3:0] err_q;
  logic [4:0] cnt_q;
  logic ack_q;
  logic wr;
  logic [3:0] pg;
  logic [7:0] ofs;
  logic [3:0] test_rise;
  logic [3:0] clr_rise;
  logic [3:0] ovf;
  logic [3:0] err_set;
  logic [3:0] flush;
  logic take;
  logic dual;
  logic p2c_valid;
  logic p2c_ready;
  logic c2i_valid;
  dic_pkg::quad_s p2c_data;
  dic_pkg::quad_s c2i_data;
  dic_pkg::quad_s cic_in;
  dic_pkg::samp_t cic_y [4];
  logic [3:0] dis;
  logic [3:0] imsk;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] wmerge(logic [31:0] old,
    logic [31:0] nw, logic [3:0] sel, logic [31:0] msk);
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        old[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    wmerge = old & msk;
  endfunction

  // Bus decode; a write lands on the edge that sees ack
  assign pg = wb_adr_i[11:8];
  assign ofs = wb_adr_i[7:0];
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wb_ack_o = ack_q;
  assign dual = ctrl_q[`DIC_F_DUAL];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        wb_dat_o <= 32'h00000000; // Unmapped and coefficients read zero
        if (pg == `DIC_PG_REGS) begin
          case (ofs)
            `DIC_OFS_CTRL: wb_dat_o <= ctrl_q;
            `DIC_OFS_CIC: wb_dat_o <= cicr_q;
            `DIC_OFS_FLUSH: wb_dat_o <= flr_q;
            `DIC_OFS_STAT: wb_dat_o <= {27'h0000000, irq_o, err_q};
            default: wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `DIC_CTRL_RST;
      cicr_q <= `DIC_CIC_RST;
      flr_q <= `DIC_FLUSH_RST;
    end else if (ce_i && wr && pg == `DIC_PG_REGS) begin
      if (ofs == `DIC_OFS_CTRL) begin
        ctrl_q <= wmerge(ctrl_q, wb_dat_i, wb_sel_i, `DIC_CTRL_MSK);
      end
      if (ofs == `DIC_OFS_CIC) begin
        cicr_q <= wmerge(cicr_q, wb_dat_i, wb_sel_i, `DIC_CIC_MSK);
      end
      if (ofs == `DIC_OFS_FLUSH) begin
        flr_q <= wmerge(flr_q, wb_dat_i, wb_sel_i, `DIC_FLUSH_MSK);
      end
    end
  end

  // Shaping FIR, one-bit optional up-shift
  dic_fir #(
    .NCOEF(`DIC_PFIR_NCOEF),
    .GW(1),
    .BASE(`DIC_PFIR_BASE)
  ) u_pfir (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cwe_i(wr && pg == `DIC_PG_PCOEF),
    .caddr_i(wb_adr_i[7:2]),
    .cdata_i(wb_dat_i[17:0]),
    .taps_i(ctrl_q[`DIC_F_PTAP]),
    .sym_i(ctrl_q[`DIC_F_SYMP]),
    .dual_i(dual),
    .gain_i(ctrl_q[`DIC_F_PGAIN]),
    .in_valid_i(in_valid_i),
    .in_data_i(in_data_i),
    .in_ready_o(in_ready_o),
    .out_valid_o(p2c_valid),
    .out_data_o(p2c_data),
    .out_ready_i(p2c_ready)
  );

  // Compensating FIR, gain 2^(g-19)
  dic_fir #(
    .NCOEF(`DIC_CFIR_NCOEF),
    .GW(3),
    .BASE(`DIC_CFIR_BASE)
  ) u_cfir (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .cwe_i(wr && pg == `DIC_PG_CCOEF),
    .caddr_i(wb_adr_i[7:2]),
    .cdata_i(wb_dat_i[17:0]),
    .taps_i(ctrl_q[`DIC_F_CTAP]),
    .sym_i(ctrl_q[`DIC_F_SYMC]),
    .dual_i(dual),
    .gain_i(ctrl_q[`DIC_F_CGAIN]),
    .in_valid_i(p2c_valid),
    .in_data_i(p2c_data),
    .in_ready_o(p2c_ready),
    .out_valid_o(c2i_valid),
    .out_data_o(c2i_data),
    .out_ready_i(take)
  );

  // CIC input strobe every ratio+1 cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 5'h00;
    end else if (ce_i) begin
      cnt_q <= (cnt_q >= ctrl_q[`DIC_F_RATIO]) ? 5'h00 : cnt_q + 5'h01;
    end
  end
  assign take = cnt_q == 5'h00;
  // Missing sample at the strobe enters as zero
  assign cic_in = (take && c2i_valid) ? c2i_data : '0;

  // Error events: overflow or test edge; flush unless disabled
  assign test_rise = flr_q[`DIC_F_TEST] & ~test_p_q;
  assign clr_rise = flr_q[`DIC_F_CLR] & ~clr_p_q;
  assign err_set = ovf | test_rise;
  assign flush = err_set & ~flr_q[`DIC_F_DIS];
  // Per-lane views of the disable and mask fields
  assign dis = flr_q[`DIC_F_DIS];
  assign imsk = flr_q[`DIC_F_IMSK];

  // Sticky error; set wins over clear edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_p_q <= 4'h0;
      clr_p_q <= 4'h0;
      err_q <= 4'h0;
    end else if (ce_i) begin
      test_p_q <= flr_q[`DIC_F_TEST];
      clr_p_q <= flr_q[`DIC_F_CLR];
      err_q <= (err_q & ~clr_rise) | err_set;
    end
  end
  assign irq_o = |(err_q & flr_q[`DIC_F_IMSK]);

  // Four CIC lanes; B pair held off in single mode
  for (genvar gi = 0; gi < 4; gi++) begin : g_cic
    dic_cic u_cic (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .en_i(gi < 2 || dual),
      .take_i(take),
      .x_i(dic_pkg::get_ch(cic_in, 2'(gi))),
      .mask_i(gi < 2 ? cicr_q[`DIC_F_MSKA] : cicr_q[`DIC_F_MSKB]),
      .scale_i(gi < 2 ? cicr_q[`DIC_F_SCA] : cicr_q[`DIC_F_SCB]),
      .flush_i(flush[gi]),
      .y_o(cic_y[gi]),
      .ovf_o(ovf[gi])
    );
  end
  assign out_data_o = {cic_y[0], cic_y[1], cic_y[2], cic_y[3]};

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);
  a_ack_pulse: assert property (ack_q |=> !ack_q)
    else $error("Bus ack held beyond one cycle");
  a_ratio_count: assert property (
    (cnt_q >= ctrl_q[`DIC_F_RATIO]) |=> take)
    else $error("CIC strobe counter past ratio");
  a_test_sets: assert property (test_rise[0] |=> err_q[0])
    else $error("Test edge did not raise error");
  a_err_sticky: assert property (
    (err_q[1] && !clr_rise[1]) |=> err_q[1])
    else $error("Error dropped without clear edge");
  a_clear_drops: assert property (
    (clr_rise[2] && !err_set[2]) |=> !err_q[2])
    else $error("Clear edge left error set");
  a_irq_gate: assert property (
    (test_rise[3] && imsk[3]) |=> irq_o)
    else $error("Unmasked error raised no interrupt");
  a_flush_reach: assert property (
    (err_set[0] && !dis[0]) |=> cic_y[0] == 18'h00000)
    else $error("Enabled auto-flush did not clear the lane");
  c_dual_run: cover property (dual && take && c2i_valid);
  c_err_set: cover property ($rose(err_q[0]));
  c_err_clear: cover property ($fell(err_q[2]));
endmodule

// [rtl/dic_pkg.sv]
// Types shared by the interpolation chain modules.
// Assumes the chain carries four 18-bit lanes: A-I, A-Q, B-I, B-Q.
package dic_pkg;
  typedef logic signed [17:0] samp_t;
  typedef struct packed {
    samp_t ai;
    samp_t aq;
    samp_t bi;
    samp_t bq;
  } quad_s;
  typedef enum logic [2:0] {
    FIR_IDLE = 3'b001,
    FIR_MAC = 3'b010,
    FIR_OUT = 3'b100
  } fir_state_e;
  // Lane pick: 0 A-I, 1 A-Q, 2 B-I, 3 B-Q
  function automatic samp_t get_ch(quad_s q, logic [1:0] ch);
    case (ch)
      2'h0: get_ch = q.ai;
      2'h1: get_ch = q.aq;
      2'h2: get_ch = q.bi;
      default: get_ch = q.bq;
    endcase
  endfunction
endpackage

// [tb/dic_chain_tb.sv]
// Self-checking bench for the interpolation chain top.
// Assumes the register map and reset values of the chain config header.
`timescale 1ns/10ps
`include "dic_cfg.svh"

module dic_chain_tb;
  logic clk_i, rst_i, ce_i, cyc, stb, we, req;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, in_valid, in_ready_o, irq_o, taken;
  dic_pkg::quad_s in_data, out_data_o, smp;
  int n_mismatch, samples_checked;
  int cycles = 0;

  dic_chain i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .in_valid_i(in_valid), .in_data_i(in_data),
    .in_ready_o(in_ready_o), .out_data_o(out_data_o), .irq_o(irq_o));

  dic_src i_src (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .smp_i(smp),
    .ready_i(in_ready_o), .valid_o(in_valid), .data_o(in_data),
    .taken_o(taken));

  // Clock at 125 MHz
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Classic single cycle; optional clock-enable stall while pending
  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    input int stall);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    if (stall > 0) begin
      ce_i <= 1'b0;
      repeat (stall) @(posedge clk_i);
      check(wb_ack_o, 1'b0); // Frozen bus gives no answer
      ce_i <= 1'b1;
    end
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    check(n < 50, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hF, 0);
    check(rdat, exp);
  endtask

  // Reset values, access masks, byte lanes, unmapped and write-only places
  task automatic t_regs();
    rd_chk(12'h000, `DIC_CTRL_RST);
    rd_chk(12'h004, `DIC_CIC_RST);
    rd_chk(12'h008, `DIC_FLUSH_RST);
    rd_chk(12'h00C, 32'h0);
    wb(1'b1, 12'h004, 32'hFFFFFFFF, 4'hF, 0);
    rd_chk(12'h004, `DIC_CIC_MSK);
    wb(1'b1, 12'h004, 32'h0, 4'hF, 2);
    rd_chk(12'h004, 32'h0);
    wb(1'b1, 12'h00C, 32'hFFFFFFFF, 4'hF, 0);
    rd_chk(12'h00C, 32'h0);
    wb(1'b1, 12'h010, 32'hFFFFFFFF, 4'hF, 0);
    rd_chk(12'h010, 32'h0);
    rd_chk(12'h104, 32'h0);
    // Single mode, 15 shaping taps, 15 comp taps (odd field), ratio 8
    wb(1'b1, 12'h000, 32'h0001CE70, 4'hF, 0);
    wb(1'b1, 12'h000, 32'hFFFFFFFF, 4'h1, 0);
    rd_chk(12'h000, 32'h0001CEFF);
    wb(1'b1, 12'h000, 32'h0001CE70, 4'hF, 0);
    rd_chk(12'h000, 32'h0001CE70);
  endtask

  // Forced error per lane, interrupt masking, persistence, clear edge
  task automatic t_err();
    logic irq_a;
    for (int l = 0; l < 4; l++) begin
      wb(1'b1, 12'h008, 32'h0000F000, 4'hF, 0);
      wb(1'b1, 12'h008, 32'h0000F000 | (32'h10 << l), 4'hF, 0);
      rd_chk(12'h00C, 32'h10 | (32'h1 << l));
      check(irq_o, 1'b1);
      irq_a = irq_o;
      wb(1'b1, 12'h008, 32'h10 << l, 4'hF, 0);
      @(negedge clk_i);
      check(irq_o ^ irq_a, 1'b1);
      wb(1'b1, 12'h008, 32'h0000F000 | (32'h10 << l), 4'hF, 0);
      repeat (20) @(posedge clk_i);
      rd_chk(12'h00C, 32'h10 | (32'h1 << l));
      wb(1'b1, 12'h008, 32'h0000F000 | (32'h110 << l), 4'hF, 0);
      rd_chk(12'h00C, 32'h0);
      check(irq_o, 1'b0);
      wb(1'b1, 12'h008, 32'h0, 4'hF, 0);
    end
  endtask

  // Sample handshake and silent output with all-zero coefficients
  task automatic t_data();
    int n;
    logic [3:0] nz;
    for (int i = 0; i < 63; i++) begin
      wb(1'b1, 12'h100 + 12'(4 * i), 32'h0, 4'hF, 0);
    end
    for (int i = 0; i < 47; i++) begin
      wb(1'b1, 12'h200 + 12'(4 * i), 32'h0, 4'hF, 0);
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      smp <= {18'h1FFFF, 18'h20000, 18'h0ABCD, 18'h3FFFF};
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (taken !== 1'b1 && n < 500);
      check(n < 500, 1'b1);
      check(in_ready_o, 1'b0);
    end
    repeat (400) @(posedge clk_i);
    check(in_ready_o, 1'b1);
    check(out_data_o, 72'h0);
    // Impulse through both modes: B lanes carry data only in dual mode
    wb(1'b1, 12'h100, 32'h00010000, 4'hF, 0);
    wb(1'b1, 12'h200, 32'h00010000, 4'hF, 0);
    wb(1'b1, 12'h004, 32'h00100010, 4'hF, 0);
    for (int m = 0; m < 2; m++) begin
      // 31 shaping and 31 comp taps, ratio 8: legal in both modes
      wb(1'b1, 12'h000, 32'h0001DEF0 | m, 4'hF, 0);
      @(posedge clk_i);
      smp <= {18'h1FFFF, 18'h20000, 18'h10000, 18'h30000};
      req <= 1'b1;
      @(posedge clk_i);
      req <= 1'b0;
      nz = 4'h0;
      repeat (400) begin
        @(posedge clk_i);
        nz = nz | {out_data_o.ai != 0, out_data_o.aq != 0,
          out_data_o.bi != 0, out_data_o.bq != 0};
      end
      check(nz, (m == 1) ? 4'hF : 4'hC);
    end
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    {cyc, stb, we, req} = 4'h0;
    adr = 12'h0;
    sel = 4'h0;
    wdat = 32'h0;
    smp = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    check(irq_o, 1'b0);
    t_regs();
    t_err();
    t_data();
    finish_test();
  end
endmodule

// [tb/dic_src.sv]
// Upstream baseband source model for the interpolation chain.
// Assumes the chain takes a sample at an edge with valid and ready high.
`timescale 1ns/10ps

module dic_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire dic_pkg::quad_s smp_i,
  input wire logic ready_i,
  output logic valid_o,
  output dic_pkg::quad_s data_o,
  output logic taken_o
);
  // Offer a sample and hold it until taken, then scramble the lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      data_o <= '0;
      taken_o <= 1'b0;
    end else begin
      taken_o <= valid_o & ready_i;
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        data_o <= ~data_o; // Released data is not left looking valid
      end else if (req_i && !valid_o) begin
        valid_o <= 1'b1;
        data_o <= smp_i;
      end
    end
  end
endmodule
